// file: verilog/mcrb_top.sv
// Password-protected configuration, shift and gain register bank
`timescale 1ns/1ps
`default_nettype none
`include "mcrb_consts.svh"
module mcrb_top (
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  input  wire logic [7:0]              host_addr_i,
  input  wire logic [7:0]              host_wdata_i,
  input  wire logic                    host_wr_i,
  input  wire logic                    host_rd_i,
  output logic      [7:0]              host_rdata_o,
  output logic                         host_rvalid_o,
  output logic                         host_refused_o,
  input  wire logic                    higher_password_level_i,
  input  wire logic                    lower_password_level_i,
  input  wire logic                    table_read_permit_i,
  input  wire logic                    table_read_write_permit_i,
  input  wire logic                    transmit_disable_input_i,
  input  wire logic                    transmit_fault_pin_i,
  input  wire logic                    internal_fault_gate_i,
  output logic                         transmit_disable_output_o,
  output logic                         clear_upper_inputs_o,
  input  wire logic                    address_source_select_i,
  output logic      [7:0]              main_slave_addr_o,
  output logic                         aux_memory_enable_o,
  output mcrb_pkg::mcrb_mode_e         strength_mode_o,
  input  wire logic                    result_valid_i,
  input  wire mcrb_pkg::mcrb_chan_e    result_chan_i,
  input  wire logic                    result_fine_i,
  input  wire logic [15:0]             result_raw_i,
  output logic                         result_valid_o,
  output logic      [15:0]             result_o,
  output logic      [15:0]             supply_gain_o,
  output logic      [15:0]             input_one_gain_o,
  output logic      [15:0]             input_two_gain_o,
  output logic      [15:0]             input_three_fine_gain_o,
  output logic      [15:0]             input_four_gain_o,
  output logic      [15:0]             input_three_coarse_gain_o
);
  import mcrb_pkg::*;

  // ----------------------------------------
  // Access decode
  // ----------------------------------------
  logic                       in_range;
  logic                       rd_ok;
  logic                       wr_ok;
  logic                       wr_take;
  logic [4:0]                 idx;
  logic [7:0]                 wmask;
  logic [7:0]                 wbyte;
  logic [`MCRB_NBYTES*8-1:0]  bytes_w;
  logic [7:0]                 sel_byte;

  assign in_range = host_addr_i >= `MCRB_OFS_FIRST && host_addr_i <= `MCRB_OFS_LAST;
  assign idx      = 5'(host_addr_i - `MCRB_OFS_FIRST);

  // Permission levels
  assign rd_ok = higher_password_level_i
               | (lower_password_level_i
                  & (table_read_permit_i | table_read_write_permit_i));
  assign wr_ok = higher_password_level_i
               | (lower_password_level_i & table_read_write_permit_i);

  assign wr_take = host_wr_i && in_range && wr_ok;

  // Reserved bits of packed registers stay zero
  always_comb begin
    if (host_addr_i == `MCRB_OFS_CONFIG) begin
      wmask = `MCRB_MASK_CONFIG;
    end else if (host_addr_i == `MCRB_OFS_SHIFT12 || host_addr_i == `MCRB_OFS_SHIFT34) begin
      wmask = `MCRB_MASK_SHIFT;
    end else begin
      wmask = `MCRB_MASK_FULL;
    end
  end

  assign wbyte = host_wdata_i & wmask;

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  mcrb_nv_store u_store (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .wr_i    (wr_take),
    .idx_i   (idx),
    .wdata_i (wbyte),
    .bytes_o (bytes_w)
  );

  assign sel_byte = in_range ? bytes_w[idx*8 +: 8] : 8'h00;

  // ----------------------------------------
  // Host read answer
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      host_rdata_o  <= 8'h00;
      host_rvalid_o <= 1'b0;
    end else begin
      host_rvalid_o <= host_rd_i;
      if (host_rd_i) begin
        host_rdata_o <= rd_ok ? sel_byte : 8'h00;
      end
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      host_refused_o <= 1'b0;
    end else begin
      host_refused_o <= (host_rd_i && !rd_ok) || (host_wr_i && !wr_ok);
    end
  end

  // ----------------------------------------
  // Field views
  // ----------------------------------------
  localparam int IX_CFG  = int'(`MCRB_OFS_CONFIG  - `MCRB_OFS_FIRST);
  localparam int IX_SLV  = int'(`MCRB_OFS_SLAVE   - `MCRB_OFS_FIRST);
  localparam int IX_S12  = int'(`MCRB_OFS_SHIFT12 - `MCRB_OFS_FIRST);
  localparam int IX_S34  = int'(`MCRB_OFS_SHIFT34 - `MCRB_OFS_FIRST);
  localparam int IX_GSUP = int'(`MCRB_OFS_G_SUPPLY - `MCRB_OFS_FIRST);
  localparam int IX_G1   = int'(`MCRB_OFS_G_ONE    - `MCRB_OFS_FIRST);
  localparam int IX_G2   = int'(`MCRB_OFS_G_TWO    - `MCRB_OFS_FIRST);
  localparam int IX_G3F  = int'(`MCRB_OFS_G_3FINE  - `MCRB_OFS_FIRST);
  localparam int IX_G4   = int'(`MCRB_OFS_G_FOUR   - `MCRB_OFS_FIRST);
  localparam int IX_G3C  = int'(`MCRB_OFS_G_3COARS - `MCRB_OFS_FIRST);

  logic [7:0] tx_disable_rssi_config;
  logic [7:0] programmable_slave_address;
  logic [7:0] shift_inputs_one_two;
  logic [7:0] shift_inputs_three_four;
  logic       clear_upper_inputs_on_disable;
  logic       fault_gate_disable_enable;
  logic       fault_pin_disable_enable;
  logic       disable_input_ignore;
  logic       strength_force_coarse;
  logic       strength_force_fine;

  assign tx_disable_rssi_config     = bytes_w[IX_CFG*8 +: 8];
  assign programmable_slave_address = bytes_w[IX_SLV*8 +: 8];
  assign shift_inputs_one_two       = bytes_w[IX_S12*8 +: 8];
  assign shift_inputs_three_four    = bytes_w[IX_S34*8 +: 8];

  assign clear_upper_inputs_on_disable = tx_disable_rssi_config[`MCRB_BIT_CLR34];
  assign fault_gate_disable_enable     = tx_disable_rssi_config[`MCRB_BIT_FGATE];
  assign fault_pin_disable_enable      = tx_disable_rssi_config[`MCRB_BIT_FPIN];
  assign disable_input_ignore          = tx_disable_rssi_config[`MCRB_BIT_IGNORE];
  assign strength_force_coarse         = tx_disable_rssi_config[`MCRB_BIT_COARSE];
  assign strength_force_fine           = tx_disable_rssi_config[`MCRB_BIT_FINE];

  // Gain words, high byte at the even offset
  assign supply_gain_o             = {bytes_w[IX_GSUP*8 +: 8], bytes_w[IX_GSUP*8+8 +: 8]};
  assign input_one_gain_o          = {bytes_w[IX_G1*8 +: 8], bytes_w[IX_G1*8+8 +: 8]};
  assign input_two_gain_o          = {bytes_w[IX_G2*8 +: 8], bytes_w[IX_G2*8+8 +: 8]};
  assign input_three_fine_gain_o   = {bytes_w[IX_G3F*8 +: 8], bytes_w[IX_G3F*8+8 +: 8]};
  assign input_four_gain_o         = {bytes_w[IX_G4*8 +: 8], bytes_w[IX_G4*8+8 +: 8]};
  assign input_three_coarse_gain_o = {bytes_w[IX_G3C*8 +: 8], bytes_w[IX_G3C*8+8 +: 8]};

  // ----------------------------------------
  // Transmit disable and flag clear
  // ----------------------------------------
  logic txd_src;
  logic flt_src;
  logic gate_src;

  assign txd_src  = transmit_disable_input_i & ~disable_input_ignore;
  assign flt_src  = transmit_fault_pin_i & fault_pin_disable_enable;
  assign gate_src = internal_fault_gate_i & fault_gate_disable_enable;

  assign transmit_disable_output_o = txd_src | flt_src | gate_src;

  // Holds while the disable input is asserted
  assign clear_upper_inputs_o = transmit_disable_input_i & clear_upper_inputs_on_disable;

  // ----------------------------------------
  // Strength mode and slave address
  // ----------------------------------------
  always_comb begin
    case ({strength_force_coarse, strength_force_fine})
      2'b01:   strength_mode_o = mode_fine;
      2'b10:   strength_mode_o = mode_coarse;
      default: strength_mode_o = mode_normal;
    endcase
  end

  assign main_slave_addr_o = address_source_select_i ? programmable_slave_address
                                                     : `MCRB_ADDR_FIXED;
  assign aux_memory_enable_o = programmable_slave_address != `MCRB_ADDR_AUX;

  // ----------------------------------------
  // Result shifting
  // ----------------------------------------
  mcrb_shift u_shift (
    .clk_i     (clk_i),
    .reset_i   (reset_i),
    .valid_i   (result_valid_i),
    .chan_i    (result_chan_i),
    .fine_i    (result_fine_i),
    .raw_i     (result_raw_i),
    .shift12_i (shift_inputs_one_two),
    .shift34_i (shift_inputs_three_four),
    .valid_o   (result_valid_o),
    .result_o  (result_o)
  );

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (reset_i);

  txd_gate_a: assert property (
    (internal_fault_gate_i && fault_gate_disable_enable) |-> transmit_disable_output_o)
    else $error("fault gate not reaching disable output");

  txd_pin_a: assert property (
    (transmit_fault_pin_i && !fault_pin_disable_enable && !txd_src && !gate_src)
      |-> !transmit_disable_output_o)
    else $error("disabled fault pin drives output");

  txd_input_a: assert property (
    (transmit_disable_input_i && !disable_input_ignore) |-> transmit_disable_output_o)
    else $error("disable input not reaching output");

  txd_or_a: assert property (
    transmit_disable_output_o
      == ((transmit_disable_input_i && !tx_disable_rssi_config[`MCRB_BIT_IGNORE])
          || (transmit_fault_pin_i && tx_disable_rssi_config[`MCRB_BIT_FPIN])
          || (internal_fault_gate_i && tx_disable_rssi_config[`MCRB_BIT_FGATE])))
    else $error("disable output is not OR of sources");

  clear_upper_a: assert property (
    clear_upper_inputs_o |-> (transmit_disable_input_i && tx_disable_rssi_config[5]))
    else $error("upper flags cleared without cause");

  mode_sel_a: assert property (
    (tx_disable_rssi_config[1:0] == 2'b10) |-> strength_mode_o == mode_coarse)
    else $error("coarse mode not forced");

  mode_fine_a: assert property (
    (tx_disable_rssi_config[1:0] == 2'b01) |-> strength_mode_o == mode_fine)
    else $error("fine mode not forced");

  slave_addr_a: assert property (
    !address_source_select_i |-> main_slave_addr_o == 8'hA2)
    else $error("fixed slave address wrong");

  aux_off_a: assert property (
    (programmable_slave_address == 8'hA0) |-> !aux_memory_enable_o)
    else $error("auxiliary memory left on");

  write_block_a: assert property (
    (host_wr_i && !wr_ok && host_addr_i == 8'h8C) |=> $stable(programmable_slave_address))
    else $error("refused write changed storage");

  write_take_a: assert property (
    (host_wr_i && wr_ok && host_addr_i == 8'h8C)
      |=> programmable_slave_address == $past(host_wdata_i))
    else $error("permitted write not stored");

  coarse_shift_a: assert property (
    (result_valid_i && result_chan_i == chan_three && !result_fine_i)
      |=> result_o == $past(result_raw_i))
    else $error("coarse third input was shifted");

  fine_shift_a: assert property (
    (result_valid_i && result_chan_i == chan_three && result_fine_i)
      |=> result_o == ($past(result_raw_i) >> $past(shift_inputs_three_four[6:4])))
    else $error("fine third input shift wrong");

  shift_one_a: assert property (
    (result_valid_i && result_chan_i == chan_one)
      |=> result_o == ($past(result_raw_i) >> $past(shift_inputs_one_two[6:4])))
    else $error("first input shift wrong");

  read_data_a: assert property (
    (host_rd_i && rd_ok && host_addr_i == `MCRB_OFS_SLAVE)
      |=> host_rdata_o == $past(programmable_slave_address))
    else $error("permitted read returned wrong byte");

  read_deny_a: assert property (
    (host_rd_i && !rd_ok) |=> (host_rdata_o == 8'h00 && host_refused_o && host_rvalid_o))
    else $error("read without permission leaked data");

  cov_write_c: cover property (host_wr_i && wr_ok && in_range);
  cov_fine_c: cover property (result_valid_i && result_chan_i == chan_three && result_fine_i);
  cov_refuse_c: cover property (host_wr_i && !wr_ok ##2 host_rd_i && rd_ok);
  cov_txd_c: cover property (clear_upper_inputs_o ##1 !transmit_disable_output_o);
endmodule
`default_nettype wire

// file: verilog/mcrb_consts.svh
// Constants for the monitor configuration register bank
`ifndef MCRB_CONSTS_SVH
`define MCRB_CONSTS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define MCRB_OFS_FIRST    8'h8B
`define MCRB_OFS_LAST     8'hA1
`define MCRB_OFS_CONFIG   8'h8B
`define MCRB_OFS_SLAVE    8'h8C
`define MCRB_OFS_RSVD_A   8'h8D
`define MCRB_OFS_SHIFT12  8'h8E
`define MCRB_OFS_SHIFT34  8'h8F
`define MCRB_OFS_RSVD_B   8'h90
`define MCRB_OFS_G_SUPPLY 8'h92
`define MCRB_OFS_G_ONE    8'h94
`define MCRB_OFS_G_TWO    8'h96
`define MCRB_OFS_G_3FINE  8'h98
`define MCRB_OFS_G_FOUR   8'h9A
`define MCRB_OFS_G_3COARS 8'h9C
`define MCRB_OFS_RSVD_C   8'h9E
`define MCRB_NBYTES       23

// ----------------------------------------
// Field positions
// ----------------------------------------
`define MCRB_BIT_CLR34    5
`define MCRB_BIT_FGATE    4
`define MCRB_BIT_FPIN     3
`define MCRB_BIT_IGNORE   2
`define MCRB_BIT_COARSE   1
`define MCRB_BIT_FINE     0
`define MCRB_SHIFT_HI     6
`define MCRB_SHIFT_LO     2

// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define MCRB_MASK_CONFIG  8'h3F
`define MCRB_MASK_SHIFT   8'h77
`define MCRB_MASK_FULL    8'hFF
`define MCRB_RST_CONFIG   8'h00
`define MCRB_RST_SHIFT34  8'h30
`define MCRB_RST_ZERO     8'h00
`define MCRB_RST_GAIN     16'h8000

// ----------------------------------------
// Slave addresses
// ----------------------------------------
`define MCRB_ADDR_FIXED   8'hA2
`define MCRB_ADDR_AUX     8'hA0

`endif

// file: verilog/mcrb_pkg.sv
// Types for the monitor configuration register bank
package mcrb_pkg;
  typedef enum logic [1:0] {mode_normal, mode_fine, mode_coarse} mcrb_mode_e;
  typedef enum logic [2:0] {chan_supply, chan_one, chan_two, chan_three, chan_four}
    mcrb_chan_e;
endpackage

// file: verilog/mcrb_nv_store.sv
// Byte store for the register bank; reset reloads the factory content of every byte
`timescale 1ns/1ps
`default_nettype none
`include "mcrb_consts.svh"
module mcrb_nv_store (
  input  wire logic                       clk_i,
  input  wire logic                       reset_i,
  input  wire logic                       wr_i,
  input  wire logic [4:0]                 idx_i,
  input  wire logic [7:0]                 wdata_i,
  output logic      [`MCRB_NBYTES*8-1:0]  bytes_o
);
  import mcrb_pkg::*;

  // Factory content of each byte; gain words are high byte first
  function automatic logic [7:0] dflt(input int i);
    logic [7:0]  ofs;
    logic [15:0] gain;
    ofs  = 8'(i) + `MCRB_OFS_FIRST;
    gain = `MCRB_RST_GAIN;
    if (ofs == `MCRB_OFS_SHIFT34) begin
      return `MCRB_RST_SHIFT34;
    end else if (ofs >= `MCRB_OFS_G_SUPPLY && ofs < `MCRB_OFS_RSVD_C) begin
      return ofs[0] ? gain[7:0] : gain[15:8];
    end else begin
      return `MCRB_RST_ZERO;
    end
  endfunction

  genvar g;
  generate
    for (g = 0; g < `MCRB_NBYTES; g++) begin : g_byte
      localparam logic [7:0] RST_VAL = dflt(g);
      logic [7:0] mem_q;
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          mem_q <= RST_VAL;
        end else if (wr_i && idx_i == 5'(g)) begin
          mem_q <= wdata_i;
        end
      end
      assign bytes_o[g*8 +: 8] = mem_q;
    end
  endgenerate
endmodule
`default_nettype wire

// file: verilog/mcrb_shift.sv
// Right shift of finished monitor results
`timescale 1ns/1ps
`default_nettype none
`include "mcrb_consts.svh"
module mcrb_shift (
  input  wire logic                    clk_i,
  input  wire logic                    reset_i,
  input  wire logic                    valid_i,
  input  wire mcrb_pkg::mcrb_chan_e    chan_i,
  input  wire logic                    fine_i,
  input  wire logic [15:0]             raw_i,
  input  wire logic [7:0]              shift12_i,
  input  wire logic [7:0]              shift34_i,
  output logic                         valid_o,
  output logic      [15:0]             result_o
);
  import mcrb_pkg::*;

  logic [2:0] amt;

  always_comb begin
    amt = 3'h0;
    case (chan_i)
      chan_one:   amt = shift12_i[`MCRB_SHIFT_HI -: 3];
      chan_two:   amt = shift12_i[`MCRB_SHIFT_LO -: 3];
      // Coarse conversions of the third input pass unshifted
      chan_three: amt = fine_i ? shift34_i[`MCRB_SHIFT_HI -: 3] : 3'h0;
      chan_four:  amt = shift34_i[`MCRB_SHIFT_LO -: 3];
      default:    amt = 3'h0;
    endcase
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      valid_o  <= 1'b0;
      result_o <= 16'h0000;
    end else begin
      valid_o <= valid_i;
      if (valid_i) begin
        result_o <= raw_i >> amt;
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/mcrb_host_model.sv
// Serial host model issuing single byte reads and writes
`timescale 1ns/1ps
`default_nettype none
module mcrb_host_model (
  input  wire logic       clk_i,
  output logic      [7:0] host_addr_o,
  output logic      [7:0] host_wdata_o,
  output logic            host_wr_o,
  output logic            host_rd_o,
  input  wire logic [7:0] host_rdata_i,
  input  wire logic       host_rvalid_i,
  input  wire logic       host_refused_i
);
  initial begin
    host_addr_o  = 8'h00;
    host_wdata_o = 8'h00;
    host_wr_o    = 1'b0;
    host_rd_o    = 1'b0;
  end

  // Released lines show the inverse so stale values never look valid
  task automatic write_byte(input logic [7:0] a, input logic [7:0] d, output logic refused);
    @(posedge clk_i);
    host_addr_o  <= a;
    host_wdata_o <= d;
    host_wr_o    <= 1'b1;
    @(posedge clk_i);
    host_wr_o    <= 1'b0;
    host_addr_o  <= ~a;
    host_wdata_o <= ~d;
    #1;
    refused = host_refused_i;
  endtask

  task automatic read_byte(input logic [7:0] a, output logic [7:0] d, output logic v,
                           output logic refused);
    @(posedge clk_i);
    host_addr_o <= a;
    host_rd_o   <= 1'b1;
    @(posedge clk_i);
    host_rd_o   <= 1'b0;
    host_addr_o <= ~a;
    #1;
    d       = host_rdata_i;
    v       = host_rvalid_i;
    refused = host_refused_i;
  endtask
endmodule
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking testbench for the monitor configuration register bank
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import mcrb_pkg::*;
  logic clk_i, reset_i, host_wr_i, host_rd_i, host_rvalid_o, host_refused_o;
  logic [7:0] host_addr_i, host_wdata_i, host_rdata_o, main_slave_addr_o, rdat;
  logic higher_password_level_i, lower_password_level_i, table_read_permit_i;
  logic table_read_write_permit_i, transmit_disable_input_i, transmit_fault_pin_i;
  logic internal_fault_gate_i, transmit_disable_output_o, clear_upper_inputs_o;
  logic address_source_select_i, aux_memory_enable_o, result_valid_i, result_fine_i;
  logic result_valid_o, rval, rref;
  mcrb_mode_e strength_mode_o;
  mcrb_chan_e result_chan_i;
  logic [15:0] result_raw_i, result_o, supply_gain_o, input_one_gain_o, input_two_gain_o;
  logic [15:0] input_three_fine_gain_o, input_four_gain_o, input_three_coarse_gain_o;
  logic [15:0] gain_seen [6];
  int failures, checked;

  assign gain_seen[0] = supply_gain_o;
  assign gain_seen[1] = input_one_gain_o;
  assign gain_seen[2] = input_two_gain_o;
  assign gain_seen[3] = input_three_fine_gain_o;
  assign gain_seen[4] = input_four_gain_o;
  assign gain_seen[5] = input_three_coarse_gain_o;

  mcrb_top i_mcrb_top (.clk_i, .reset_i, .host_addr_i, .host_wdata_i, .host_wr_i, .host_rd_i,
    .host_rdata_o, .host_rvalid_o, .host_refused_o, .higher_password_level_i,
    .lower_password_level_i, .table_read_permit_i, .table_read_write_permit_i,
    .transmit_disable_input_i, .transmit_fault_pin_i, .internal_fault_gate_i,
    .transmit_disable_output_o, .clear_upper_inputs_o, .address_source_select_i,
    .main_slave_addr_o, .aux_memory_enable_o, .strength_mode_o, .result_valid_i,
    .result_chan_i, .result_fine_i, .result_raw_i, .result_valid_o, .result_o,
    .supply_gain_o, .input_one_gain_o, .input_two_gain_o, .input_three_fine_gain_o,
    .input_four_gain_o, .input_three_coarse_gain_o);

  mcrb_host_model i_mcrb_host_model (.clk_i, .host_addr_o(host_addr_i),
    .host_wdata_o(host_wdata_i), .host_wr_o(host_wr_i), .host_rd_o(host_rd_i),
    .host_rdata_i(host_rdata_o), .host_rvalid_i(host_rvalid_o),
    .host_refused_i(host_refused_o));

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_mcrb_host_model.write_byte(a, d, rref);
  endtask

  task automatic rd(input logic [7:0] a);
    i_mcrb_host_model.read_byte(a, rdat, rval, rref);
  endtask

  task automatic close_out;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset;
    rd(8'h8B);
    check("config", rdat, 8'h00);
    check("rvalid", rval, 1'b1);
    rd(8'h8F);
    check("shift34", rdat, 8'h30);
    rd(8'h8D);
    check("rsvd_a", rdat, 8'h00);
    rd(8'hA1);
    check("rsvd_c", rdat, 8'h00);
    check("gain_supply", supply_gain_o, 16'h8000);
    check("gain_coarse", input_three_coarse_gain_o, 16'h8000);
    check("main_addr", main_slave_addr_o, 8'hA2);
    check("aux", aux_memory_enable_o, 1'b1);
    check("mode", strength_mode_o, mode_normal);
    $display("test reset done");
  endtask

  task automatic t_txd;
    wr(8'h8B, 8'hFF);
    rd(8'h8B);
    check("config_mask", rdat, 8'h3F);
    for (int c = 0; c < 16; c++) begin
      wr(8'h8B, 8'(c << 2));
      for (int s = 0; s < 8; s++) begin
        @(posedge clk_i);
        {transmit_disable_input_i, transmit_fault_pin_i, internal_fault_gate_i} <= 3'(s);
        #1;
        check("txd_out", transmit_disable_output_o,
              (s[2] & ~c[0]) | (s[1] & c[1]) | (s[0] & c[2]));
        check("clear", clear_upper_inputs_o, s[2] & c[3]);
      end
    end
    for (int m = 0; m < 4; m++) begin
      wr(8'h8B, 8'(m));
      check("mode", strength_mode_o,
            (m == 1) ? mode_fine : (m == 2) ? mode_coarse : mode_normal);
    end
    $display("test transmit disable and mode done");
  endtask

  task automatic t_addr;
    wr(8'h8C, 8'h55);
    @(posedge clk_i);
    address_source_select_i <= 1'b1;
    #1;
    check("main_addr", main_slave_addr_o, 8'h55);
    check("aux", aux_memory_enable_o, 1'b1);
    wr(8'h8C, 8'hA0);
    check("aux", aux_memory_enable_o, 1'b0);
    check("main_addr", main_slave_addr_o, 8'hA0);
    @(posedge clk_i);
    address_source_select_i <= 1'b0;
    #1;
    check("main_addr", main_slave_addr_o, 8'hA2);
    wr(8'h8C, 8'hA1);
    check("aux", aux_memory_enable_o, 1'b1);
    $display("test slave address done");
  endtask

  task automatic send(input mcrb_chan_e ch, input logic fine, input logic [15:0] exp);
    @(posedge clk_i);
    result_valid_i <= 1'b1;
    result_chan_i  <= ch;
    result_fine_i  <= fine;
    result_raw_i   <= 16'hF000;
    @(posedge clk_i);
    result_valid_i <= 1'b0;
    result_raw_i   <= 16'h0FFF;
    #1;
    check("res_valid", result_valid_o, 1'b1);
    check("result", result_o, exp);
  endtask

  task automatic t_shift;
    send(chan_three, 1'b1, 16'h1E00);
    wr(8'h8E, 8'hFF);
    rd(8'h8E);
    check("shift12_mask", rdat, 8'h77);
    wr(8'h8E, 8'h25);
    wr(8'h8F, 8'h13);
    send(chan_one, 1'b0, 16'h3C00);
    send(chan_two, 1'b0, 16'h0780);
    send(chan_three, 1'b1, 16'h7800);
    send(chan_three, 1'b0, 16'hF000);
    send(chan_four, 1'b0, 16'h1E00);
    send(chan_supply, 1'b0, 16'hF000);
    $display("test shift done");
  endtask

  task automatic t_gain;
    for (int i = 0; i < 6; i++) begin
      wr(8'(8'h92 + 2 * i), 8'(8'h11 * (i + 1)));
      wr(8'(8'h93 + 2 * i), 8'(8'hA0 + i));
    end
    for (int i = 0; i < 6; i++) begin
      check("gain", gain_seen[i], {8'(8'h11 * (i + 1)), 8'(8'hA0 + i)});
    end
    $display("test gain done");
  endtask

  task automatic t_perm;
    logic [7:0] stored;
    logic       rok;
    logic       wok;
    stored = 8'hA1;
    for (int k = 0; k < 16; k++) begin
      rok = k[3] | (k[2] & (k[1] | k[0]));
      wok = k[3] | (k[2] & k[0]);
      @(posedge clk_i);
      {higher_password_level_i, lower_password_level_i, table_read_permit_i,
       table_read_write_permit_i} <= 4'(k);
      wr(8'h8C, 8'(8'h40 + k));
      check("wr_refused", rref, !wok);
      if (wok) begin
        stored = 8'(8'h40 + k);
      end
      rd(8'h8C);
      check("rd_refused", rref, !rok);
      check("rd_data", rdat, rok ? stored : 8'h00);
    end
    @(posedge clk_i);
    {higher_password_level_i, lower_password_level_i} <= 2'b10;
    rd(8'h8A);
    check("unmapped", {rdat, 7'h00, rref}, 16'h0000);
    $display("test password done");
  endtask

  // ----------------------------------------
  // Clock, reset, sequence and watchdog
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  initial begin
    reset_i = 1'b1;
    {higher_password_level_i, lower_password_level_i} = 2'b10;
    {table_read_permit_i, table_read_write_permit_i} = 2'b00;
    {transmit_disable_input_i, transmit_fault_pin_i, internal_fault_gate_i} = 3'b000;
    address_source_select_i = 1'b0;
    {result_valid_i, result_fine_i} = 2'b00;
    result_chan_i = chan_supply;
    result_raw_i = 16'h0000;
    failures = 0;
    checked = 0;
    repeat (12) @(posedge clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_txd();
    t_addr();
    t_shift();
    t_gain();
    t_perm();
    close_out();
  end

  initial begin
    repeat (20000) @(posedge clk_i);
    failures++;
    close_out();
  end
endmodule
`default_nettype wire
